// ---- logic/cmc_pkg.sv ----
// Purpose: shared constants and types for the can mode control and status block
// Assumes: 20 MHz reference clock, 32-bit register port with byte offsets
// Notes:   buffer codes are shared by window select and interrupt code; mode codes by requested and current mode
package cmc_pkg;
    typedef enum logic [2:0] {
        MODE_NORMAL   = 3'b000,
        MODE_DISABLE  = 3'b001,
        MODE_LOOPBACK = 3'b010,
        MODE_LISTEN   = 3'b011,
        MODE_CONFIG   = 3'b100
    } cmc_mode_t;

    typedef enum logic [2:0] {
        BUF_NONE = 3'b000,
        BUF_ERR  = 3'b001,
        BUF_TX2  = 3'b010,
        BUF_TX1  = 3'b011,
        BUF_TX0  = 3'b100,
        BUF_RXLO = 3'b101,
        BUF_RXHI = 3'b110,
        BUF_WAKE = 3'b111
    } cmc_code_t;

    localparam logic [6:0] OFS_CONTROL  = 7'h00;
    localparam logic [6:0] OFS_STATUS   = 7'h04;
    localparam logic [6:0] OFS_INT_FLAG = 7'h08;
    localparam logic [6:0] OFS_INT_MASK = 7'h0c;
    localparam logic [6:0] OFS_TX_CTRL  = 7'h10;
    localparam logic [6:0] OFS_BIT_CYC  = 7'h14;
    localparam logic [6:0] OFS_WAKE_LEN = 7'h18;
    localparam logic [6:0] OFS_MISC     = 7'h1c;
    localparam logic [6:0] OFS_FILT0    = 7'h20;
    localparam logic [6:0] OFS_MASK0    = 7'h38;
    localparam logic [6:0] OFS_MASK1    = 7'h3c;
    localparam logic [6:0] OFS_RXHI_ID  = 7'h40;
    localparam logic [6:0] OFS_RXLO_ID  = 7'h44;

    localparam int         CTL_REQ_LSB   = 5;
    localparam int         CTL_ABORT_BIT = 4;
    localparam int         CTL_WIN_LSB   = 1;
    localparam int         STS_OVF_LSB   = 8;
    localparam int         TXC_PRIO_LSB  = 4;
    localparam int         FLT_EXT_BIT   = 30;
    localparam logic [7:0] CONTROL_RESET = 8'h80;
    localparam int         INT_W         = 7;
    localparam int         IX_ERR        = 0;
    localparam int         IX_TX2        = 1;
    localparam int         IX_TX1        = 2;
    localparam int         IX_TX0        = 3;
    localparam int         IX_RXLO       = 4;
    localparam int         IX_RXHI       = 5;
    localparam int         IX_WAKE       = 6;

    localparam int         CLK_HZ        = 20_000_000;
    localparam int         MAX_BPS       = 1_000_000;
    localparam int         MIN_BIT_CYC   = CLK_HZ / MAX_BPS;
    localparam logic [7:0] BIT_CYC_RESET = 8'h28;
    localparam logic [7:0] WAKE_LEN_RST  = 8'h10;
    localparam logic [3:0] MAX_DLC       = 4'h8;
endpackage

// ---- logic/cmc_top.sv ----
// Purpose: can controller top control: modes, abort, window, interrupt code, filters
// Assumes: protocol engine on the same clock supplies frames, idle and error states
// Notes:   bus receive pin is asynchronous and is synchronised before use
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// [RQ1] requested mode decodes: top bit config, 011 listen, 010 loopback, 001 disable, 000 normal
// [RQ2] current mode reports 100/011/010/001/000; codes 101..111 never appear
// [RQ3] abort bit held at one cancels pending transmissions in all three buffers
// [RQ4] window selector maps one buffer; 101 rx low, 100/011/010 tx, others rx high
// [RQ5] interrupt source code is prioritized: wake, rx high, rx low, tx0..tx2, error, none
// [RQ6] buffer codes of interrupt source equal window select codes
// [RQ7] software should enter disable mode before the device sleeps
// [RQ8] control bit 0 and status bits 4 and 0 always read zero
// [RQ9] software sets receive pin as input and transmit pin as output first
// [RQ10] frames are error checked, then filtered; only matches are stored in a receive buffer
// [RQ11] six filters and two masks; two filters for rx high, four for rx low
// [RQ12] standard and extended frames with 0..8 bytes and remote frames are handled
// [RQ13] bit rate programmable, never faster than one megabit per second
// [RQ14] three transmit buffers sent in software priority order, each abortable
// [RQ15] loopback mode receives own frames internally for self test
// [RQ16] bus activity wakes the device through a programmable glitch filter
// [RQ17] every receiver and transmitter error state can raise an interrupt
// [RQ18] frame events produce a time-stamp strobe toward a timer when enabled
// [RQ19] after reset both mode fields show config; current changes once transition completes
module cmc_top
    import cmc_pkg::*;
#(
    parameter int N_FILT = 6
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RESET_N,
    input  wire logic [6:0]  I_ADDR,
    input  wire logic [31:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [31:0] O_RDATA,
    output logic             O_IRQ,
    input  wire logic        I_BUS_RX_PIN,
    input  wire logic        I_BUS_IDLE,
    input  wire logic        I_FRAME_VALID,
    input  wire logic        I_FRAME_ERR,
    input  wire logic [28:0] I_FRAME_ID,
    input  wire logic        I_FRAME_EXT,
    input  wire logic        I_FRAME_RTR,
    input  wire logic [3:0]  I_FRAME_DLC,
    input  wire logic        I_TX_DONE,
    input  wire logic        I_TX_FAIL,
    input  wire logic [2:0]  I_ERR_STATE,
    output logic             O_TX_START,
    output logic      [1:0]  O_TX_BUF,
    output logic      [2:0]  O_MODE,
    output logic      [2:0]  O_WINDOW_BUF,
    output logic             O_BIT_TICK,
    output logic             O_TIMESTAMP
);
    initial begin
        if (N_FILT != 6) $error("cmc_top: filter count must be 6");
    end

    logic [7:0]        control_r;
    cmc_mode_t         cur_mode_r;
    logic [INT_W-1:0]  int_flag_r;
    logic [INT_W-1:0]  int_mask_r;
    logic [2:0]        tx_req_r;
    logic [5:0]        tx_prio_r;
    logic              tx_active_r;
    logic [1:0]        tx_idx_r;
    logic [7:0]        bit_cyc_r;
    logic [7:0]        bit_cnt_r;
    logic [7:0]        wake_len_r;
    logic [7:0]        wake_cnt_r;
    logic              wake_seen_r;
    logic              ts_en_r;
    logic [30:0]       filt_r [N_FILT];
    logic [28:0]       mask_r [2];
    logic [30:0]       rxhi_id_r;
    logic [30:0]       rxlo_id_r;
    logic [1:0]        ovf_r;
    logic [2:0]        err_state_r;
    logic              rx_sync1_r;
    logic              rx_sync2_r;
    logic [31:0]       rdata_r;
    logic              tick_r;
    logic              ts_r;

    // [RQ1] requested mode decode
    cmc_mode_t req_mode;
    always_comb begin
        if (control_r[CTL_REQ_LSB+2]) begin
            req_mode = MODE_CONFIG;
        end else begin
            unique case (control_r[CTL_REQ_LSB+1 -: 2])
                2'b11: req_mode = MODE_LISTEN;
                2'b10: req_mode = MODE_LOOPBACK;
                2'b01: req_mode = MODE_DISABLE;
                2'b00: req_mode = MODE_NORMAL;
            endcase
        end
    end

    logic abort_all;
    assign abort_all = control_r[CTL_ABORT_BIT];

    // [RQ4] window decode; [RQ6] shares the interrupt code encoding
    logic [2:0] win_sel;
    cmc_code_t  win_buf;
    assign win_sel = control_r[CTL_WIN_LSB +: 3];
    always_comb begin
        unique case (win_sel)
            BUF_RXLO: win_buf = BUF_RXLO;
            BUF_TX0:  win_buf = BUF_TX0;
            BUF_TX1:  win_buf = BUF_TX1;
            BUF_TX2:  win_buf = BUF_TX2;
            default:  win_buf = BUF_RXHI;
        endcase
    end

    // bus strobes
    logic wr_ctl;
    logic wr_flag;
    logic wr_txc;
    assign wr_ctl  = I_WR && I_ADDR == OFS_CONTROL;
    assign wr_flag = I_WR && I_ADDR == OFS_INT_FLAG;
    assign wr_txc  = I_WR && I_ADDR == OFS_TX_CTRL;

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            control_r <= CONTROL_RESET;                       // [RQ19]
        end else if (wr_ctl) begin
            control_r <= {I_WDATA[7:1], 1'b0};                // [RQ8]
        end
    end

    // [RQ19] current mode follows request only when the engine is idle
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            cur_mode_r <= MODE_CONFIG;
        end else if (cur_mode_r != req_mode && I_BUS_IDLE && !tx_active_r) begin
            cur_mode_r <= req_mode;                           // [RQ2]
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            int_mask_r <= '0;
            bit_cyc_r  <= BIT_CYC_RESET;
            wake_len_r <= WAKE_LEN_RST;
            ts_en_r    <= 1'b0;
            tx_prio_r  <= '0;
            mask_r[0]  <= '0;
            mask_r[1]  <= '0;
        end else if (I_WR) begin
            if (I_ADDR == OFS_INT_MASK) int_mask_r <= I_WDATA[INT_W-1:0];
            if (I_ADDR == OFS_BIT_CYC)  bit_cyc_r  <= I_WDATA[7:0];
            if (I_ADDR == OFS_WAKE_LEN) wake_len_r <= I_WDATA[7:0];
            if (I_ADDR == OFS_MISC)     ts_en_r    <= I_WDATA[0];
            if (wr_txc)                 tx_prio_r  <= I_WDATA[TXC_PRIO_LSB +: 6];
            if (I_ADDR == OFS_MASK0)    mask_r[0]  <= I_WDATA[28:0];
            if (I_ADDR == OFS_MASK1)    mask_r[1]  <= I_WDATA[28:0];
        end
    end

    // [RQ11] six filters, first two steer to the high priority buffer
    logic [N_FILT-1:0] hit;
    for (genvar g = 0; g < N_FILT; g++) begin : g_filt
        always_ff @(posedge I_REF_CLK) begin
            if (!I_RESET_N) begin
                filt_r[g] <= '0;
            end else if (I_WR && I_ADDR == OFS_FILT0 + 7'(4 * g)) begin
                filt_r[g] <= I_WDATA[30:0];
            end
        end
        assign hit[g] = filt_r[g][FLT_EXT_BIT] == I_FRAME_EXT &&
                        ((filt_r[g][28:0] ^ I_FRAME_ID) & mask_r[g < 2 ? 0 : 1]) == 29'h0;
    end

    // [RQ10] error check precedes filtering; [RQ12] dlc 0..8
    logic rx_mode_ok;
    logic frame_ok;
    logic rx_hi;
    logic rx_lo;
    assign rx_mode_ok = cur_mode_r == MODE_NORMAL || cur_mode_r == MODE_LISTEN ||
                        cur_mode_r == MODE_LOOPBACK;                    // [RQ15]
    assign frame_ok = I_FRAME_VALID && !I_FRAME_ERR && rx_mode_ok && I_FRAME_DLC <= MAX_DLC;
    assign rx_hi = frame_ok && |hit[1:0];
    assign rx_lo = frame_ok && !(|hit[1:0]) && |hit[N_FILT-1:2];

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            rxhi_id_r <= '0;
            rxlo_id_r <= '0;
        end else begin
            if (rx_hi && !int_flag_r[IX_RXHI]) begin
                rxhi_id_r <= {I_FRAME_RTR, I_FRAME_EXT, I_FRAME_ID};   // [RQ10]
            end
            if (rx_lo && !int_flag_r[IX_RXLO]) begin
                rxlo_id_r <= {I_FRAME_RTR, I_FRAME_EXT, I_FRAME_ID};   // [RQ12]
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            ovf_r <= '0;
        end else begin
            ovf_r[0] <= (rx_hi && int_flag_r[IX_RXHI]) ||
                        (ovf_r[0] && !(I_WR && I_ADDR == OFS_STATUS && I_WDATA[STS_OVF_LSB]));
            ovf_r[1] <= (rx_lo && int_flag_r[IX_RXLO]) ||
                        (ovf_r[1] && !(I_WR && I_ADDR == OFS_STATUS && I_WDATA[STS_OVF_LSB+1]));
        end
    end

    // [RQ14] transmit arbitration by software priority, higher index on ties
    logic       tx_mode_ok;
    logic       tx_pick_v;
    logic [1:0] tx_pick;
    logic [1:0] best_prio;
    assign tx_mode_ok = cur_mode_r == MODE_NORMAL || cur_mode_r == MODE_LOOPBACK;
    always_comb begin
        tx_pick_v = 1'b0;
        tx_pick   = 2'd0;
        best_prio = 2'd0;
        for (int k = 0; k < 3; k++) begin
            if (tx_req_r[k] && (!tx_pick_v || tx_prio_r[2*k +: 2] >= best_prio)) begin
                tx_pick_v = 1'b1;
                tx_pick   = 2'(k);
                best_prio = tx_prio_r[2*k +: 2];
            end
        end
    end

    logic tx_launch;
    assign tx_launch = tx_pick_v && !tx_active_r && tx_mode_ok && I_BUS_IDLE && !abort_all;

    logic [2:0] tx_done_vec;
    for (genvar t = 0; t < 3; t++) begin : g_tx
        assign tx_done_vec[t] = tx_active_r && I_TX_DONE && tx_idx_r == 2'(t) && tx_req_r[t];
        always_ff @(posedge I_REF_CLK) begin
            if (!I_RESET_N) begin
                tx_req_r[t] <= 1'b0;
            end else if (abort_all || tx_done_vec[t]) begin
                tx_req_r[t] <= 1'b0;                                   // [RQ3]
            end else if (wr_txc) begin
                tx_req_r[t] <= I_WDATA[t];                             // [RQ14]
            end
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            tx_active_r <= 1'b0;
            tx_idx_r    <= 2'd0;
        end else if (tx_active_r) begin
            if (I_TX_DONE || I_TX_FAIL) tx_active_r <= 1'b0;
        end else if (tx_launch) begin
            tx_active_r <= 1'b1;
            tx_idx_r    <= tx_pick;
        end
    end

    // [RQ16] wake filter: dominant level held for the programmed length
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            rx_sync1_r <= 1'b1;
            rx_sync2_r <= 1'b1;
        end else begin
            rx_sync1_r <= I_BUS_RX_PIN;
            rx_sync2_r <= rx_sync1_r;
        end
    end

    logic wake_evt;
    assign wake_evt = cur_mode_r == MODE_DISABLE && !rx_sync2_r && !wake_seen_r &&
                      wake_cnt_r >= wake_len_r;
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            wake_cnt_r  <= '0;
            wake_seen_r <= 1'b0;
        end else if (cur_mode_r != MODE_DISABLE || rx_sync2_r) begin
            wake_cnt_r  <= '0;
            wake_seen_r <= 1'b0;
        end else begin
            if (wake_cnt_r != 8'hff) wake_cnt_r <= wake_cnt_r + 8'h01;  // [RQ16]
            if (wake_evt) wake_seen_r <= 1'b1;
        end
    end

    // [RQ17] any newly reached error state raises the error flag
    logic err_evt;
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) err_state_r <= '0;
        else            err_state_r <= I_ERR_STATE;
    end
    assign err_evt = |(I_ERR_STATE & ~err_state_r);

    // sticky flags, write one to clear, set wins
    logic [INT_W-1:0] int_set;
    assign int_set = {wake_evt, rx_hi, rx_lo, tx_done_vec[0], tx_done_vec[1], tx_done_vec[2], err_evt};
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            int_flag_r <= '0;
        end else begin
            int_flag_r <= int_set | (int_flag_r & ~(wr_flag ? I_WDATA[INT_W-1:0] : '0));
        end
    end

    // [RQ5] prioritized source code over unmasked pending flags
    logic [INT_W-1:0] pend;
    cmc_code_t        icode;
    assign pend = int_flag_r & int_mask_r;
    always_comb begin
        icode = BUF_NONE;
        for (int k = 0; k < INT_W; k++) begin
            if (pend[k]) icode = cmc_code_t'(3'(k + 1));              // [RQ6]
        end
    end

    // [RQ13] bit tick never faster than the minimum bit period
    logic [7:0] bit_len;
    assign bit_len = bit_cyc_r < 8'(MIN_BIT_CYC) ? 8'(MIN_BIT_CYC) : bit_cyc_r;
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N || cur_mode_r == MODE_CONFIG) begin
            bit_cnt_r <= '0;
            tick_r    <= 1'b0;
        end else if (bit_cnt_r >= bit_len - 8'h01) begin
            bit_cnt_r <= '0;
            tick_r    <= 1'b1;
        end else begin
            bit_cnt_r <= bit_cnt_r + 8'h01;
            tick_r    <= 1'b0;
        end
    end

    // [RQ18] time-stamp strobe
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) ts_r <= 1'b0;
        else            ts_r <= ts_en_r && (rx_hi || rx_lo || |tx_done_vec);
    end

    // register read, answer one cycle later
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESET_N) begin
            rdata_r <= '0;
        end else if (I_RD) begin
            rdata_r <= '0;
            unique case (I_ADDR)
                OFS_CONTROL:  rdata_r[7:0] <= control_r;
                OFS_STATUS:   rdata_r[9:0] <= {ovf_r, cur_mode_r, 1'b0, icode, 1'b0}; // [RQ8]
                OFS_INT_FLAG: rdata_r[INT_W-1:0] <= int_flag_r;
                OFS_INT_MASK: rdata_r[INT_W-1:0] <= int_mask_r;
                OFS_TX_CTRL:  rdata_r[9:0] <= {tx_prio_r, 1'b0, tx_req_r};
                OFS_BIT_CYC:  rdata_r[7:0] <= bit_cyc_r;
                OFS_WAKE_LEN: rdata_r[7:0] <= wake_len_r;
                OFS_MISC:     rdata_r[0] <= ts_en_r;
                OFS_MASK0:    rdata_r[28:0] <= mask_r[0];
                OFS_MASK1:    rdata_r[28:0] <= mask_r[1];
                OFS_RXHI_ID:  rdata_r[30:0] <= rxhi_id_r;
                OFS_RXLO_ID:  rdata_r[30:0] <= rxlo_id_r;
                default: begin
                    for (int k = 0; k < N_FILT; k++) begin
                        if (I_ADDR == OFS_FILT0 + 7'(4 * k)) rdata_r[30:0] <= filt_r[k];
                    end
                end
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    assign O_RDATA      = rdata_r;
    assign O_IRQ        = |pend;
    assign O_TX_START   = tx_launch;
    assign O_TX_BUF     = tx_launch ? tx_pick : tx_idx_r;
    assign O_MODE       = cur_mode_r;
    assign O_WINDOW_BUF = win_buf;
    assign O_BIT_TICK   = tick_r;
    assign O_TIMESTAMP  = ts_r;

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESET_N);

    property p_req_config;
        control_r[7] && I_BUS_IDLE && !tx_active_r |=> cur_mode_r == MODE_CONFIG;
    endproperty
    a_req_config: assert property (p_req_config) else $error("config request not honoured"); // [RQ1]

    property p_mode_legal;
        cur_mode_r inside {MODE_NORMAL, MODE_DISABLE, MODE_LOOPBACK, MODE_LISTEN, MODE_CONFIG};
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("reserved mode reported"); // [RQ2]

    property p_abort;
        abort_all |=> tx_req_r == 3'b000 && !O_TX_START;
    endproperty
    a_abort: assert property (p_abort) else $error("abort left a pending buffer"); // [RQ3]

    property p_window;
        win_sel == 3'b101 |-> O_WINDOW_BUF == BUF_RXLO;
    endproperty
    a_window: assert property (p_window) else $error("window select wrong"); // [RQ4]

    property p_icode_wake;
        pend[IX_WAKE] |-> icode == BUF_WAKE && O_IRQ;
    endproperty
    a_icode_wake: assert property (p_icode_wake) else $error("wake not top priority"); // [RQ5]

    property p_icode_tx0;
        pend[IX_TX0] && pend[INT_W-1:IX_RXLO] == '0 |-> icode == BUF_TX0;
    endproperty
    a_icode_tx0: assert property (p_icode_tx0) else $error("tx0 code mismatch"); // [RQ6]

    property p_unimpl;
        I_RD && (I_ADDR == OFS_CONTROL || I_ADDR == OFS_STATUS) |=>
            O_RDATA[0] == 1'b0 && (O_RDATA[4] == 1'b0 || $past(I_ADDR) != OFS_STATUS);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set"); // [RQ8]

    property p_err_frame;
        I_FRAME_VALID && I_FRAME_ERR && !int_flag_r[IX_RXHI] |=> !int_flag_r[IX_RXHI];
    endproperty
    a_err_frame: assert property (p_err_frame) else $error("bad frame stored"); // [RQ10]

    sequence s_tick;
        tick_r ##1 !tick_r [*8];
    endsequence
    property p_rate;
        tick_r |-> s_tick;
    endproperty
    a_rate: assert property (p_rate) else $error("bit rate too fast"); // [RQ13]

    property p_err_irq;
        err_evt |=> int_flag_r[IX_ERR];
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("error state lost"); // [RQ17]

    property p_mode_hold;
        !I_BUS_IDLE |=> $stable(cur_mode_r);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed while busy"); // [RQ19]
endmodule
`default_nettype wire

// ---- bench/cmc_engine_model.sv ----
// Purpose: behavioural protocol engine beside the control block
// Assumes: one clock, frames and transfers shortened to a few cycles
// Notes:   frame fields scramble outside the valid pulse
`timescale 1ns/1ps
`default_nettype none
module cmc_engine_model (
    input  wire logic        i_clk,
    input  wire logic        i_hold,
    input  wire logic        i_slow,
    input  wire logic        i_tx_start,
    input  wire logic        i_rx_go,
    input  wire logic        i_rx_err,
    input  wire logic [28:0] i_rx_id,
    input  wire logic [3:0]  i_rx_dlc,
    output logic             o_bus_idle,
    output logic             o_frame_valid,
    output logic             o_frame_err,
    output logic      [28:0] o_frame_id,
    output logic      [3:0]  o_frame_dlc,
    output logic             o_tx_done
);
    logic [3:0] cnt_r = 4'h0;
    initial begin
        o_frame_valid = 1'b0;
        o_frame_err = 1'b0;
        o_frame_id = 29'h0;
        o_frame_dlc = 4'h0;
        o_tx_done = 1'b0;
    end
    assign o_bus_idle = !i_hold && cnt_r == 4'h0 && !i_rx_go && !o_frame_valid;
    always @(posedge i_clk) begin
        o_tx_done <= 1'b0;
        if (i_tx_start && cnt_r == 4'h0)
            cnt_r <= i_slow ? 4'h8 : 4'h2;
        else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
            o_tx_done <= cnt_r == 4'h1;
        end
        o_frame_valid <= i_rx_go;
        o_frame_err <= i_rx_go ? i_rx_err : ~o_frame_err;
        o_frame_id <= i_rx_go ? i_rx_id : ~o_frame_id;
        o_frame_dlc <= i_rx_go ? i_rx_dlc : ~o_frame_dlc;
    end
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the can mode control block
// Assumes: engine model stands for the protocol engine
// Notes:   reads are checked by a monitor from a queue of expectations
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cmc_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [6:0]  addr = 7'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [2:0]  err_st = 3'h0;
    logic        hold = 1'b0;
    logic        slow = 1'b0;
    logic        rx_go = 1'b0;
    logic        rx_err = 1'b0;
    logic [28:0] rx_id = 29'h0;
    logic [3:0]  rx_dlc = 4'h0;
    logic        rd_d = 1'b0;
    logic        rx_pin = 1'b1;
    logic [31:0] tk_n = 32'h0, ts_n = 32'h0, c;
    logic [31:0] rdata;
    logic        irq, tx_start, idle, fv, ferr, tx_done, tick, ts;
    logic [28:0] fid, id_hi, id_lo;
    logic [3:0]  fdlc;
    logic [1:0]  tx_buf;
    logic [2:0]  mode, win, r;
    logic [31:0] exp_q[$];
    int          err_count = 0;
    int          total_checks = 0;
    integer      seed = 32'hafef;
    always #25 clk = ~clk;
    cmc_top cmc_top_inst (.I_REF_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq), .I_BUS_RX_PIN(rx_pin), .I_BUS_IDLE(idle),
        .I_FRAME_VALID(fv), .I_FRAME_ERR(ferr), .I_FRAME_ID(fid), .I_FRAME_EXT(1'b0),
        .I_FRAME_RTR(1'b0), .I_FRAME_DLC(fdlc), .I_TX_DONE(tx_done), .I_TX_FAIL(1'b0),
        .I_ERR_STATE(err_st), .O_TX_START(tx_start), .O_TX_BUF(tx_buf), .O_MODE(mode),
        .O_WINDOW_BUF(win), .O_BIT_TICK(tick), .O_TIMESTAMP(ts));
    cmc_engine_model cmc_engine_model_inst (.i_clk(clk), .i_hold(hold), .i_slow(slow),
        .i_tx_start(tx_start), .i_rx_go(rx_go), .i_rx_err(rx_err), .i_rx_id(rx_id),
        .i_rx_dlc(rx_dlc), .o_bus_idle(idle), .o_frame_valid(fv), .o_frame_err(ferr),
        .o_frame_id(fid), .o_frame_dlc(fdlc), .o_tx_done(tx_done));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (err_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr_reg(input logic [6:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [6:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] q, input logic ab, input logic [2:0] w);
        return {24'h0, q, ab, w, 1'b1};
    endfunction
    task automatic wait_mode(input logic [2:0] m);
        for (int k = 0; k < 20 && mode !== m; k++)
            @(posedge clk);
        #1;
        chk({29'h0, mode}, {29'h0, m});
    endtask
    task automatic rx(input logic [28:0] id, input logic e);
        @(posedge clk);
        rx_go <= 1'b1;
        rx_id <= id;
        rx_err <= e;
        rx_dlc <= 4'($unsigned($random(seed)) % 9);
        @(posedge clk);
        rx_go <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        tk_n <= tk_n + 32'(tick);
        ts_n <= ts_n + 32'(ts);
        if (rd_d)
            chk(rdata, exp_q.pop_front());
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(OFS_CONTROL, 32'h80);
        rd_reg(OFS_STATUS, 32'h80);
        rd_reg(7'h7c, 32'h0);
        chk({29'h0, win}, 32'h6);
        for (int w = 0; w < 8; w++) begin
            r = 3'b100 | 3'($random(seed));
            wr_reg(OFS_CONTROL, ctl(r, 1'b0, 3'(w)));
            chk({29'h0, win}, (w >= 2 && w <= 5) ? 32'(w) : 32'h6);
            rd_reg(OFS_CONTROL, {24'h0, r, 1'b0, 3'(w), 1'b0});
            chk({29'h0, mode}, 32'h4);
        end
        hold <= 1'b1;
        wr_reg(OFS_CONTROL, ctl(3'b000, 1'b0, 3'b000));
        repeat (5) @(posedge clk);
        #1;
        chk({29'h0, mode}, 32'h4);
        hold <= 1'b0;
        wait_mode(3'b000);
        for (int m = 3; m >= 0; m--) begin
            wr_reg(OFS_CONTROL, ctl(3'(m), 1'b0, 3'b000));
            wait_mode(3'(m));
            rd_reg(OFS_STATUS, 32'(m) << 5);
        end
        id_hi = (29'($random(seed)) & 29'h7ff) | 29'h1;
        id_lo = id_hi ^ 29'h400;
        wr_reg(OFS_FILT0, {3'h0, id_hi});
        wr_reg(OFS_FILT0 + 7'h08, {3'h0, id_lo});
        wr_reg(OFS_MASK0, 32'h1fffffff);
        wr_reg(OFS_MASK1, 32'h1fffffff);
        wr_reg(OFS_INT_MASK, 32'h7f);
        rx(id_hi, 1'b1);
        rd_reg(OFS_INT_FLAG, 32'h0);
        err_st <= 3'b001;
        repeat (3) @(posedge clk);
        rd_reg(OFS_STATUS, 32'h02);
        slow <= 1'b1;
        wr_reg(OFS_TX_CTRL, 32'h4);
        chk({30'h0, tx_buf}, 32'h2);
        for (int k = 0; k < 20 && !tx_done; k++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        rd_reg(OFS_STATUS, 32'h04);
        wr_reg(OFS_MISC, 32'h1);
        rx(id_lo, 1'b0);
        rd_reg(OFS_STATUS, 32'h0a);
        rx(id_hi, 1'b0);
        rd_reg(OFS_STATUS, 32'h0c);
        rx(29'h0, 1'b0);
        rd_reg(OFS_STATUS, 32'h10c);
        rd_reg(OFS_RXHI_ID, {3'h0, id_hi});
        wr_reg(OFS_STATUS, 32'h100);
        wr_reg(OFS_INT_FLAG, 32'h20);
        rd_reg(OFS_STATUS, 32'h0a);
        wr_reg(OFS_CONTROL, ctl(3'b000, 1'b0, 3'b101));
        chk({29'h0, win}, 32'h5);
        wr_reg(OFS_INT_MASK, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr_reg(OFS_INT_MASK, 32'h7f);
        chk({31'h0, irq}, 32'h1);
        wr_reg(OFS_INT_FLAG, 32'h7f);
        chk({31'h0, irq}, 32'h0);
        rd_reg(OFS_STATUS, 32'h0);
        wr_reg(OFS_CONTROL, ctl(3'b000, 1'b1, 3'b000));
        wr_reg(OFS_TX_CTRL, 32'h7);
        repeat (4) begin
            chk({31'h0, tx_start}, 32'h0);
            @(posedge clk);
            #1;
        end
        rd_reg(OFS_TX_CTRL, 32'h0);
        wr_reg(OFS_CONTROL, ctl(3'b000, 1'b0, 3'b000));
        chk({31'h0, tx_start}, 32'h0);
        wr_reg(OFS_CONTROL, ctl(3'b001, 1'b0, 3'b000));
        wait_mode(3'b001);
        c = tk_n;
        rx_pin <= 1'b0;
        repeat (80) @(posedge clk);
        #1;
        rx_pin <= 1'b1;
        chk(tk_n - c, 32'h2);
        rd_reg(OFS_STATUS, 32'h2e);
        chk(ts_n, 32'h3);
        repeat (3) @(posedge clk);
        finish_test;
    end
endmodule
`default_nettype wire
